/* hdl/afs_pkg.sv */
// constants and types of the converter front end serial access block
package afs_pkg;
  localparam logic [4:0] A_CHAN0    = 5'h00;
  localparam logic [4:0] A_CHAN0_LO = 5'h02;
  localparam logic [4:0] A_CHAN1    = 5'h03;
  localparam logic [4:0] A_CHAN1_LO = 5'h05;
  localparam logic [4:0] A_MODULATOR = 5'h06;
  localparam logic [4:0] A_PHASE_HI = 5'h07;
  localparam logic [4:0] A_PHASE_LO = 5'h08;
  localparam logic [4:0] A_STAT_HI  = 5'h0a;
  localparam logic [4:0] A_STAT_LO  = 5'h0b;
  localparam logic [4:0] A_CONF_HI  = 5'h0c;
  localparam logic [4:0] A_CONF_LO  = 5'h0d;
  localparam logic [4:0] A_LAST     = 5'h1a;
  // group bounds, lowest group in the low slot
  localparam logic [6:0][4:0] GRP_FIRST = {5'h1a, 5'h14, 5'h0e, 5'h0a, 5'h06, 5'h03, 5'h00};
  localparam logic [6:0][4:0] GRP_LAST  = {5'h1a, 5'h19, 5'h13, 5'h0d, 5'h09, 5'h05, 5'h02};
  // status/comm high byte fields
  localparam int RDY_MODE_LSB  = 6;
  localparam int RDY_IDLE_BIT  = 5;
  // status/comm low byte fields
  localparam int READ_LSB      = 6;
  localparam int WRITE_BIT     = 5;
  localparam int WIDTH_LSB     = 3;
  // configuration low byte fields
  localparam int SRST_LSB      = 6;
  localparam int SHDN_LSB      = 4;
  localparam int MOD_PIN_LSB   = 2;
  // values after reset
  localparam logic [7:0] MODULATOR_RST = 8'h33;
  localparam logic [7:0] STAT_HI_RST   = 8'h20;
  localparam logic [7:0] STAT_LO_RST   = 8'ha0;
  localparam logic [1:0] DEV_ADDR_RST  = 2'h0;
  // ready pulse width in core cycles, stands for one modulator clock
  localparam int RDY_PULSE_CYC = 4;
  localparam int FIFO_DEPTH    = 8;
  typedef enum logic [1:0] {LOOP_STATIC, LOOP_GROUP, LOOP_TYPE, LOOP_MAP} afs_loop_type;
  typedef enum logic [2:0] {PH_IDLE, PH_CTRL, PH_READ, PH_WRITE, PH_IGNORE} afs_phase_type;
  typedef struct packed {
    logic [23:0] chan1;
    logic [23:0] chan0;
  } afs_set_type;
endpackage

/* hdl/afs_serial_loop.sv */
// serial access loop of the dual converter front end, with its result fifo
`timescale 1ns/1ns
// Function
// - idle-low mode sees rising edge first
// - one control byte, loop until select high
// - loop selector picks static/group/type/map looping
// - width selector sets 16 or 24 bit channels
// - skip low byte of 16-bit channels
// - idle-low: output refreshed with new MSB
// - idle-high: output keeps last driven level
// - power-up defaults, ready pulses start at once
// - zero codes, modulator 0011, zero phase
// - group looping uses seven address groups
// - type looping uses data and configuration types
// - clocking or phase changes restart converters
// - rewriting phase also restarts converters
// - ready pin pulses low one modulator period
// - idle ready pin floats or drives high
// - ready pulses ignore chip select
// - hard reset held low silences ready pin
// - first latch links channels in mode 00
// - second latch freezes data during a read
// - drive on falling, sample on rising edge
// - control byte address; foreign device ignored
// - write increment wraps to first writable
// - undefined reads zero, writes ignored, no advance

module afs_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = afs_pkg::FIFO_DEPTH
) (
  input  wire logic             core_clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } afs_fifo_st_type;
  afs_fifo_st_type r, n;
  logic push, pop;

  assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o  = r.mem[r.rp];
  assign push = in_valid_i & in_ready_o;
  assign pop  = out_valid_o & out_ready_i;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_i;
      n.wp = (r.wp == AW'(DEPTH-1)) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == AW'(DEPTH-1)) ? '0 : r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end
endmodule

module afs_serial_loop #(
  parameter logic [1:0] DEV_ADDR  = afs_pkg::DEV_ADDR_RST,
  parameter int         RDY_PULSE = afs_pkg::RDY_PULSE_CYC
) (
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        ce_i,
  input  wire logic        rst_pin_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        sdi_i,
  output logic             sdo_o,
  output logic             sdo_oe_o,
  output logic             conversion_ready_pin_o,
  output logic             conversion_ready_pin_oe_o,
  input  wire logic        chan0_done_i,
  input  wire logic [23:0] chan0_data_i,
  input  wire logic        chan1_done_i,
  input  wire logic [23:0] chan1_data_i,
  output logic [1:0]       soft_reset_o,
  output logic [1:0]       shutdown_o,
  output logic             restart_o
);
  typedef struct packed {
    afs_pkg::afs_phase_type ph;
    logic                   sclk_q;
    logic                   cs_q;
    logic [2:0]             bits;
    logic [7:0]             sh_in;
    logic [7:0]             sh_out;
    logic [4:0]             addr;
    logic                   sdo;
    logic                   sdo_en;
    logic [26:6][7:0]       cfg;
    afs_pkg::afs_set_type   s1;
    logic [1:0]             seen;
    logic                   push_pend;
    afs_pkg::afs_set_type   s2;
    logic [1:0]             rd_mask;
    logic [3:0]             rdy_cnt;
    logic                   restart;
  } afs_st_type;

  afs_st_type           r, n;
  logic                 rise, fall, take, pop, fifo_in_ready, fifo_out_valid;
  afs_pkg::afs_set_type fifo_out;
  logic [1:0]           rd_loop, width, rdy_mode;
  logic                 c0w, c1w;

  function automatic afs_st_type rst_state();
    afs_st_type s;
    s = '0;
    s.cfg[afs_pkg::A_MODULATOR] = afs_pkg::MODULATOR_RST;
    s.cfg[afs_pkg::A_STAT_HI]   = afs_pkg::STAT_HI_RST;
    s.cfg[afs_pkg::A_STAT_LO]   = afs_pkg::STAT_LO_RST;
    s.rd_mask = 2'h3;
    return s;
  endfunction

  function automatic logic [7:0] rd_byte(input logic [4:0] a, input afs_st_type s);
    case (a)
      5'h00:   rd_byte = s.s2.chan0[23:16];
      5'h01:   rd_byte = s.s2.chan0[15:8];
      5'h02:   rd_byte = s.s2.chan0[7:0];
      5'h03:   rd_byte = s.s2.chan1[23:16];
      5'h04:   rd_byte = s.s2.chan1[15:8];
      5'h05:   rd_byte = s.s2.chan1[7:0];
      default: rd_byte = (a <= afs_pkg::A_LAST) ? s.cfg[a] : 8'h00;
    endcase
  endfunction

  function automatic logic [4:0] next_rd(input logic [4:0] a, input logic [1:0] lp,
                                         input logic w0, input logic w1);
    logic [4:0] lo, hi, nx;
    logic       hit;
    lo = 5'h00;
    hi = afs_pkg::A_LAST;
    hit = 1'b0;
    case (afs_pkg::afs_loop_type'(lp))
      afs_pkg::LOOP_GROUP: begin
        for (int i = 0; i < 7; i++) begin
          if (!hit && a <= afs_pkg::GRP_LAST[i]) begin
            lo = afs_pkg::GRP_FIRST[i];
            hi = afs_pkg::GRP_LAST[i];
            hit = 1'b1;
          end
        end
      end
      afs_pkg::LOOP_TYPE: begin
        if (a < afs_pkg::A_MODULATOR) begin
          hi = afs_pkg::A_CHAN1_LO;
        end else begin
          lo = afs_pkg::A_MODULATOR;
        end
      end
      default: ;
    endcase
    nx = (a == hi) ? lo : a + 5'h01;
    if ((nx == afs_pkg::A_CHAN0_LO && !w0) || (nx == afs_pkg::A_CHAN1_LO && !w1)) begin
      nx = (nx == hi) ? lo : nx + 5'h01;
    end
    if (lp == 2'h0 || a > afs_pkg::A_LAST) begin
      nx = a;
    end
    return nx;
  endfunction

  assign rise     = sclk_i & ~r.sclk_q;
  assign fall     = ~sclk_i & r.sclk_q;
  assign rd_loop  = r.cfg[afs_pkg::A_STAT_LO][afs_pkg::READ_LSB +: 2];
  assign width    = r.cfg[afs_pkg::A_STAT_LO][afs_pkg::WIDTH_LSB +: 2];
  assign rdy_mode = r.cfg[afs_pkg::A_STAT_HI][afs_pkg::RDY_MODE_LSB +: 2];
  assign c0w      = |width;
  assign c1w      = &width;
  assign soft_reset_o = r.cfg[afs_pkg::A_CONF_LO][afs_pkg::SRST_LSB +: 2];
  assign shutdown_o   = r.cfg[afs_pkg::A_CONF_LO][afs_pkg::SHDN_LSB +: 2];
  assign restart_o    = r.restart;
  assign sdo_o        = r.sdo;
  assign sdo_oe_o     = r.sdo_en & ~cs_n_i;
  // chip select plays no part here
  assign conversion_ready_pin_o    = (r.rdy_cnt == 4'h0);
  assign conversion_ready_pin_oe_o = rst_pin_n_i & ((r.rdy_cnt != 4'h0) |
                                     r.cfg[afs_pkg::A_STAT_HI][afs_pkg::RDY_IDLE_BIT]);

  always_comb begin
    logic       chs, at_start;
    logic [7:0] b;
    n = r;
    pop = 1'b0;
    chs = (r.addr == afs_pkg::A_CHAN1);
    at_start = (r.addr == afs_pkg::A_CHAN0) || chs;
    b = 8'h00;
    n.restart = 1'b0;
    n.sclk_q = sclk_i;
    n.cs_q = cs_n_i;
    // ready pulse and first latch stage
    if (r.rdy_cnt != 4'h0) begin
      n.rdy_cnt = r.rdy_cnt - 4'h1;
    end
    if (chan0_done_i) begin
      n.s1.chan0 = chan0_data_i;
      n.seen[0] = 1'b1;
    end
    if (chan1_done_i) begin
      n.s1.chan1 = chan1_data_i;
      n.seen[1] = 1'b1;
    end
    case (rdy_mode)
      2'h0:    take = &n.seen & ~|soft_reset_o & ~|shutdown_o;
      2'h1:    take = chan0_done_i;
      2'h2:    take = chan1_done_i;
      default: take = chan0_done_i | chan1_done_i;
    endcase
    if (fifo_in_ready) begin
      n.push_pend = 1'b0;
    end
    if (take) begin
      n.push_pend = 1'b1; // set wins over the drain
      n.seen = 2'h0;
      n.rdy_cnt = 4'(RDY_PULSE);
    end
    if (|soft_reset_o || |shutdown_o || r.restart) begin
      n.seen = 2'h0;
    end
    // serial side
    if (cs_n_i) begin
      n.ph = afs_pkg::PH_IDLE;
      n.sdo_en = 1'b0;
      n.bits = 3'h0;
    end else if (r.cs_q) begin
      n.ph = afs_pkg::PH_CTRL;
      n.bits = 3'h0;
    end else if (rise) begin
      n.sh_in = {r.sh_in[6:0], sdi_i};
      n.bits = r.bits + 3'h1;
      if (r.bits == 3'h7) begin
        case (r.ph)
          afs_pkg::PH_CTRL: begin
            n.addr = n.sh_in[5:1];
            if (n.sh_in[7:6] != DEV_ADDR) begin
              n.ph = afs_pkg::PH_IGNORE;
            end else if (n.sh_in[0]) begin
              n.ph = afs_pkg::PH_READ;
            end else begin
              n.ph = afs_pkg::PH_WRITE;
            end
          end
          afs_pkg::PH_READ: begin
            n.addr = next_rd(r.addr, rd_loop, c0w, c1w);
          end
          afs_pkg::PH_WRITE: begin
            if (r.addr >= afs_pkg::A_MODULATOR && r.addr <= afs_pkg::A_LAST) begin
              n.cfg[r.addr] = n.sh_in;
              if (r.addr == afs_pkg::A_PHASE_HI || r.addr == afs_pkg::A_PHASE_LO ||
                  (r.addr == afs_pkg::A_CONF_HI && n.sh_in != r.cfg[r.addr]) ||
                  (r.addr == afs_pkg::A_CONF_LO &&
                   n.sh_in[afs_pkg::MOD_PIN_LSB +: 2] !=
                   r.cfg[r.addr][afs_pkg::MOD_PIN_LSB +: 2])) begin
                n.restart = 1'b1;
              end
            end
            if (r.addr <= afs_pkg::A_LAST && r.cfg[afs_pkg::A_STAT_LO][afs_pkg::WRITE_BIT]) begin
              n.addr = (r.addr == afs_pkg::A_LAST) ? afs_pkg::A_MODULATOR
                                                   : r.addr + 5'h01;
            end
          end
          default: ;
        endcase
        n.sh_out = rd_byte(n.addr, n);
      end
    end else if (r.ph == afs_pkg::PH_READ && r.bits == 3'h0 && at_start &&
                 (fall || (!sclk_i && r.sdo_en && fifo_out_valid && r.rd_mask[chs]))) begin
      // one clock: the pulse start is already a registered core event
      // idle refresh waits for the set to land, an empty one would shift stale bits
      b = r.sh_out;
      if (fifo_out_valid && r.rd_mask[chs]) begin
        pop = 1'b1;
        n.s2 = fifo_out;
        n.rd_mask = 2'h0;
        b = chs ? fifo_out.chan1[23:16] : fifo_out.chan0[23:16];
      end
      n.rd_mask[chs] = 1'b1;
      if (fall) begin
        n.sdo = b[7];
        n.sh_out = {b[6:0], 1'b0};
        n.sdo_en = 1'b1;
      end else if (r.sdo_en) begin
        n.sdo = b[7];
        n.sh_out = {b[6:0], 1'b0};
      end
    end else if (fall && r.ph == afs_pkg::PH_READ) begin
      n.sdo = r.sh_out[7];
      n.sh_out = {r.sh_out[6:0], 1'b0};
      n.sdo_en = 1'b1;
    end
    if (!rst_pin_n_i) begin
      n = rst_state();
    end
  end

  afs_fifo #(.WIDTH(48), .DEPTH(afs_pkg::FIFO_DEPTH)) u_fifo (
    .core_clk_i  (core_clk_i),
    .srst_i      (srst_i),
    .ce_i        (ce_i),
    .in_valid_i  (r.push_pend),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (r.s1),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (pop),
    .out_data_o  (fifo_out)
  );

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      r <= rst_state();
    end else if (ce_i) begin
      r <= n;
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i || !ce_i);

  sequence low_pulse_s;
    !conversion_ready_pin_o [*4] ##1 conversion_ready_pin_o;
  endsequence
  sequence phase_write_s;
    rst_pin_n_i && !cs_n_i && !r.cs_q && rise && r.bits == 3'h7 &&
    r.ph == afs_pkg::PH_WRITE &&
    (r.addr == afs_pkg::A_PHASE_HI || r.addr == afs_pkg::A_PHASE_LO);
  endsequence

  ready_width_a: assert property ($fell(conversion_ready_pin_o) && !take |->
    ##1 (!conversion_ready_pin_o [*3] ##1 conversion_ready_pin_o) or (##[1:3] take))
    else $error("ready pulse width wrong");
  ready_start_a: assert property (take && rst_pin_n_i |=>
    low_pulse_s or ##[1:4] take)
    else $error("ready pulse shape wrong");
  sdo_float_a: assert property (cs_n_i |-> !sdo_oe_o)
    else $error("serial output driven while deselected");
  ready_silent_a: assert property (!rst_pin_n_i |->
    !conversion_ready_pin_oe_o ##1 conversion_ready_pin_o)
    else $error("ready pin active in hard reset");
  ready_idle_a: assert property (conversion_ready_pin_o && rst_pin_n_i |->
    conversion_ready_pin_oe_o == r.cfg[afs_pkg::A_STAT_HI][afs_pkg::RDY_IDLE_BIT])
    else $error("ready pin idle drive wrong");
  phase_restart_a: assert property (phase_write_s |=> restart_o ##1 !restart_o)
    else $error("phase write gave no restart");
  skip_low_a: assert property (r.ph == afs_pkg::PH_READ &&
    $past(r.ph) == afs_pkg::PH_READ &&
    r.addr == afs_pkg::A_CHAN0_LO && $past(r.addr) != afs_pkg::A_CHAN0_LO |-> c0w)
    else $error("low byte of short channel visited");
  static_loop_a: assert property (r.ph == afs_pkg::PH_READ && rd_loop == 2'h0 &&
    $past(r.ph) == afs_pkg::PH_READ && $past(rd_loop) == 2'h0 |-> $stable(r.addr))
    else $error("static loop moved address");
  foreign_dev_a: assert property (r.ph == afs_pkg::PH_IGNORE |->
    !sdo_oe_o && !r.restart)
    else $error("foreign transfer acted upon");
endmodule

/* verif/afs_host_model.sv */
// host side serial master model for the front end serial block
`timescale 1ns/1ns
module afs_host_model (
  input  wire logic core_clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  logic idle_high = 1'b0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // clock parked at its idle level before select falls
  task automatic open_frame(input logic [7:0] ctrl);
    logic [7:0] q;
    sclk_o <= idle_high;
    wait_clk(4);
    cs_n_o <= 1'b0;
    wait_clk(4);
    xfer(ctrl, q); // single control byte, then data only
  endtask
  // msb first; every bit shifted, sampled before the rise
  task automatic xfer(input logic [7:0] wr, output logic [7:0] rd);
    for (int i = 7; i >= 0; i--) begin
      if (idle_high) sclk_o <= 1'b0;
      sdi_o <= wr[i];
      wait_clk(4);
      // an undriven line reads as the inverse, so a late enable shows up
      @(negedge core_clk_i) rd[i] = sdo_oe_i ? sdo_i : ~sdo_i;
      @(posedge core_clk_i) sclk_o <= 1'b1;
      wait_clk(4);
      if (!idle_high) sclk_o <= 1'b0;
    end
  endtask
  // data line flipped once deselected, never left at a stale level
  task automatic close_frame();
    wait_clk(4);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    wait_clk(4);
  endtask
endmodule

/* verif/test_afs_serial_loop.sv */
// self-checking bench of the serial access loop
`timescale 1ns/1ns
module test_afs_serial_loop;
  localparam logic [1:0] DEV = afs_pkg::DEV_ADDR_RST;
  localparam int         RDY = afs_pkg::RDY_PULSE_CYC;
  // start address and three expected bytes per loop selector value
  localparam logic [3:0][28:0] LOOPS = {{5'h09, 24'h0020f8}, {5'h1a, 24'h003300},
                                        {5'h09, 24'h003300}, {5'h06, 24'h333333}};
  logic        core_clk_i;
  logic        srst_i;
  logic        rst_pin_n_i;
  logic        sclk, cs_n, sdi, sdo, sdo_oe, pin, pin_oe, restart;
  logic        chan0_done, chan1_done, ce;
  logic [23:0] d0, d1;
  logic [1:0]  soft_rst, shdn;
  int          n_mismatch = 0;
  int          n_tests = 0;
  int          n_restart = 0;
  int          n_low = 0;
  int          n_oe = 0;

  afs_serial_loop dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce), .rst_pin_n_i(rst_pin_n_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sdo_oe_o(sdo_oe),
    .conversion_ready_pin_o(pin), .conversion_ready_pin_oe_o(pin_oe),
    .chan0_done_i(chan0_done), .chan0_data_i(d0), .chan1_done_i(chan1_done),
    .chan1_data_i(d1), .soft_reset_o(soft_rst), .shutdown_o(shdn), .restart_o(restart)
  );
  afs_host_model host (
    .core_clk_i(core_clk_i), .sdo_i(sdo), .sdo_oe_i(sdo_oe), .sclk_o(sclk), .cs_n_o(cs_n),
    .sdi_o(sdi)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #4 core_clk_i = ~core_clk_i;
  end

  // pulse cycles counted only while the pin is driven
  always @(posedge core_clk_i) begin
    if (restart === 1'b1) n_restart <= n_restart + 1;
    if (pin_oe === 1'b1 && pin === 1'b0) n_low <= n_low + 1;
    if (sdo_oe === 1'b1) n_oe <= n_oe + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic rd_byte(input logic [7:0] exp);
    logic [7:0] q;
    host.xfer(8'h00, q);
    check(32'(q), 32'(exp));
  endtask
  task automatic rd1(input logic [4:0] a, input logic [7:0] exp);
    host.open_frame({DEV, a, 1'b1});
    rd_byte(exp);
    host.close_frame();
  endtask
  task automatic wr(input logic [1:0] dev, input logic [4:0] a, input logic [15:0] v);
    logic [7:0] q;
    host.open_frame({dev, a, 1'b0});
    host.xfer(v[15:8], q);
    host.xfer(v[7:0], q);
    host.close_frame();
  endtask
  task automatic conv(input logic c0, input logic c1, input logic [47:0] v);
    @(posedge core_clk_i);
    chan0_done <= c0;
    chan1_done <= c1;
    {d1, d0} <= v;
    @(posedge core_clk_i);
    chan0_done <= 1'b0;
    chan1_done <= 1'b0;
    repeat (12) @(posedge core_clk_i);
  endtask
  // both channels at 16 bits: low bytes skipped
  task automatic rd_set16(input logic [47:0] s);
    rd_byte(s[23:16]);
    rd_byte(s[15:8]);
    rd_byte(s[47:40]);
    rd_byte(s[39:32]);
  endtask

  task automatic t_reset();
    check(32'({pin, pin_oe, sdo_oe, restart}), 32'hc);
    check(32'({soft_rst, shdn}), 32'h0);
  endtask
  task automatic t_defaults();
    logic [47:0] e;
    e = 48'h3300_0000_20a0;
    host.open_frame({DEV, afs_pkg::A_MODULATOR, 1'b1});
    for (int k = 5; k >= 0; k--) rd_byte(e[8*k+:8]);
    host.close_frame();
  endtask
  task automatic t_ready();
    int l0;
    l0 = n_low;
    conv(1'b1, 1'b0, 48'h3cd207_8142ff);
    check(n_low - l0, 0);
    conv(1'b0, 1'b1, 48'h3cd207_8142ff);
    check(n_low - l0, RDY);
  endtask
  task automatic t_stream();
    host.open_frame({DEV, afs_pkg::A_CHAN0, 1'b1});
    rd_set16(48'h3cd207_8142ff);
    repeat (6) @(posedge core_clk_i);
    check(32'(sdo), 32'h1);
    conv(1'b1, 1'b1, 48'hc3186b_5ea199);
    check(32'(sdo), 32'h0);
    rd_set16(48'hc3186b_5ea199);
    host.close_frame();
  endtask
  task automatic t_loops();
    logic [28:0] t;
    for (int m = 0; m < 4; m++) begin
      t = LOOPS[m];
      wr(DEV, afs_pkg::A_STAT_LO, {2'(m), 6'b111000, 8'h00});
      host.open_frame({DEV, t[28:24], 1'b1});
      for (int k = 2; k >= 0; k--) rd_byte(t[8*k+:8]);
      host.close_frame();
    end
  endtask
  task automatic t_restart();
    logic [55:0] cfg;
    logic [7:0]  q;
    int          r0, l0;
    cfg = 56'h000000_20a0_0000;
    wr(DEV, afs_pkg::A_CONF_LO, 16'hc0c0);
    check(32'(soft_rst), 32'h3);
    l0 = n_low;
    conv(1'b1, 1'b1, 48'h0);
    check(n_low - l0, 0);
    r0 = n_restart;
    host.open_frame({DEV, afs_pkg::A_PHASE_HI, 1'b0});
    for (int k = 6; k >= 0; k--) host.xfer(cfg[8*k+:8], q);
    host.close_frame();
    check(32'(n_restart > r0), 32'h1);
    check(32'(soft_rst), 32'h0);
    rd1(afs_pkg::A_STAT_LO, 8'ha0);
    r0 = n_restart;
    wr(DEV, afs_pkg::A_CONF_HI, 16'h0000); // same values, no restart wanted
    check(n_restart - r0, 0);
    wr(DEV, afs_pkg::A_CONF_HI, 16'h053c);
    check(32'(shdn), 32'h3);
    check(n_restart - r0, 2);
    wr(DEV, afs_pkg::A_CONF_LO, 16'h0000);
  endtask
  task automatic t_refuse();
    logic [7:0] q;
    int         o0;
    o0 = n_oe;
    host.open_frame({DEV ^ 2'h1, afs_pkg::A_MODULATOR, 1'b1});
    host.xfer(8'h00, q);
    host.close_frame();
    check(n_oe - o0, 0);
    wr(DEV ^ 2'h1, afs_pkg::A_MODULATOR, 16'h5555);
    rd1(afs_pkg::A_MODULATOR, 8'h33);
    wr(DEV, afs_pkg::A_CHAN1_LO, 16'h556b); // data byte ignored, address still steps
    rd1(afs_pkg::A_MODULATOR, 8'h6b);
    wr(DEV, 5'h1b, 16'h7777);
    rd1(5'h1b, 8'h00);
  endtask
  task automatic t_idle_high();
    host.idle_high = 1'b1;
    host.open_frame({DEV, afs_pkg::A_MODULATOR, 1'b1});
    rd_byte(8'h6b);
    repeat (8) @(posedge core_clk_i);
    check(32'(sdo), 32'h1);
    host.close_frame();
    host.idle_high = 1'b0;
  endtask
  task automatic t_pin();
    int l0;
    wr(DEV, afs_pkg::A_STAT_HI, 16'h00a0);
    check(32'(pin_oe), 32'h0);
    l0 = n_low;
    conv(1'b1, 1'b1, 48'h0);
    check(n_low - l0, RDY);
    wr(DEV, afs_pkg::A_STAT_HI, 16'h40a0); // channel zero events only
    conv(1'b0, 1'b1, 48'h0);
    check(n_low - l0, RDY);
    conv(1'b1, 1'b0, 48'h0);
    check(n_low - l0, 2 * RDY);
    // a frozen core must miss the event altogether
    ce <= 1'b0;
    conv(1'b1, 1'b1, 48'h0);
    ce <= 1'b1;
    check(n_low - l0, 2 * RDY);
    rst_pin_n_i <= 1'b0;
    conv(1'b1, 1'b1, 48'h0);
    check(n_low - l0, 2 * RDY);
    check(32'(pin_oe), 32'h0);
    rst_pin_n_i <= 1'b1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge core_clk_i);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    srst_i = 1'b1;
    rst_pin_n_i = 1'b1;
    ce = 1'b1;
    chan0_done = 1'b0;
    chan1_done = 1'b0;
    d0 = 24'h0;
    d1 = 24'h0;
    repeat (16) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset();
    t_defaults();
    t_ready();
    t_stream();
    t_loops();
    t_restart();
    t_refuse();
    t_idle_high();
    t_pin();
    report_and_stop();
  end
endmodule
